// ==== src/ledks_consts.vh ====
// Constants shared by the LED display and key scan controller.
`ifndef LEDKS_CONSTS_VH
`define LEDKS_CONSTS_VH

`define LEDKS_CMD_MODE     2'b00
`define LEDKS_CMD_DATA     2'b01
`define LEDKS_CMD_CTRL     2'b10
`define LEDKS_CMD_ADDR     2'b11
`define LEDKS_MODE_RESET   2'b11
`define LEDKS_DATA_WRITE   2'b00
`define LEDKS_DATA_READ    2'b10
`define LEDKS_B_FIXED      2
`define LEDKS_B_TEST       3
`define LEDKS_B_ON         3
`define LEDKS_ADDR_RESET   4'h0
`define LEDKS_ADDR_LIMIT   4'hE
`define LEDKS_RAM_DEPTH    14
`define LEDKS_PW_RESET     3'h0
`define LEDKS_KEY_BITS     6'h28
`define LEDKS_FIFO_WIDTH   9
`define LEDKS_FIFO_DEPTH   16
`define LEDKS_TICK_NS      1000
`define LEDKS_CLK_NS       25
`define LEDKS_TICK_LAST    8'h27
`define LEDKS_SLOT_LAST    4'hF
`define LEDKS_KEY_SRC_LAST 4'h9
`define LEDKS_PW0          4'h1
`define LEDKS_PW1          4'h2
`define LEDKS_PW2          4'h4
`define LEDKS_PW3          4'hA
`define LEDKS_PW4          4'hB
`define LEDKS_PW5          4'hC
`define LEDKS_PW6          4'hD
`define LEDKS_PW7          4'hE

`endif

// ==== src/ledks_fifo.v ====
// Byte FIFO between the serial receiver and the command interpreter.
`timescale 1ns/1ps
module ledks_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_q];

	always @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule

// ==== src/ledks_scan.v ====
// Grid multiplexer, dimming and key matrix scanner.
`timescale 1ns/1ps
`include "ledks_consts.vh"
module ledks_scan (
	input  wire          clk,
	input  wire          rst_n,
	input  wire [1:0]    mode,
	input  wire          disp_on,
	input  wire [2:0]    pulse_sel,
	input  wire [111:0]  ram_flat,
	input  wire [1:0]    key_in,
	output reg  [9:0]    seg_q,
	output reg  [2:0]    seg_grid_q,
	output reg  [3:0]    grid_q,
	output reg  [19:0]   key_q
);

	reg  [7:0]  tick_q;
	reg  [3:0]  sub_q;
	reg  [2:0]  slot_q;
	reg  [19:0] stage_q;
	reg  [3:0]  width;
	wire [2:0]  last_grid = {1'b0, mode} + 3'h3;
	wire        tick_end  = (tick_q == `LEDKS_TICK_LAST);
	wire        slot_end  = tick_end && (sub_q == `LEDKS_SLOT_LAST);
	wire        key_slot  = (slot_q == last_grid + 3'h1);
	wire        light     = disp_on && (sub_q < width);
	wire [7:0]  even_b    = ram_flat[{slot_q, 4'h0} +: 8];
	wire [7:0]  odd_b     = ram_flat[{slot_q, 4'h8} +: 8];
	wire [2:0]  sg_seg    = {odd_b[5], odd_b[4], odd_b[3]};
	wire [2:0]  sg_grid;
	reg  [3:0]  gr_d;
	reg  [9:0]  seg_d;
	reg  [2:0]  sg_d;

	// -----------------------------------------------------------------
	// Pulse width table
	// -----------------------------------------------------------------
	always @* begin
		case (pulse_sel)
			3'h0:    width = `LEDKS_PW0;
			3'h1:    width = `LEDKS_PW1;
			3'h2:    width = `LEDKS_PW2;
			3'h3:    width = `LEDKS_PW3;
			3'h4:    width = `LEDKS_PW4;
			3'h5:    width = `LEDKS_PW5;
			3'h6:    width = `LEDKS_PW6;
			default: width = `LEDKS_PW7;
		endcase
	end

	// -----------------------------------------------------------------
	// Shared pins: pin j carries grid 7-j once the mode reaches it
	// -----------------------------------------------------------------
	genvar j;
	generate
		for (j = 0; j < 3; j = j + 1) begin : g_sg
			assign sg_grid[j] = (last_grid >= 3'd6 - j[2:0]);
		end
	endgenerate

	always @* begin
		gr_d  = 4'h0;
		seg_d = 10'h000;
		sg_d  = 3'h0;
		if (key_slot) begin
			if (sub_q <= `LEDKS_KEY_SRC_LAST) begin
				seg_d = 10'h001 << sub_q;
			end
		end else begin
			// Grids rest while the display is off; the key slot keeps scanning
			if (disp_on && slot_q < 3'h4) begin
				gr_d = 4'h1 << slot_q[1:0];
			end
			sg_d = (sg_grid & (3'h4 >> (slot_q - 3'h4)) & {3{slot_q >= 3'h4 && disp_on}}) |
				(~sg_grid & sg_seg & {3{light}});
			seg_d = {odd_b[1:0], even_b} & {10{light}};
		end
	end

	// -----------------------------------------------------------------
	// Slot sequencing: n grid slots plus one key slot per cycle
	// -----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q     <= 8'h00;
			sub_q      <= 4'h0;
			slot_q     <= 3'h0;
			stage_q    <= 20'h00000;
			key_q      <= 20'h00000;
			seg_q      <= 10'h000;
			seg_grid_q <= 3'h0;
			grid_q     <= 4'h0;
		end else begin
			seg_q      <= seg_d;
			seg_grid_q <= sg_d;
			grid_q     <= gr_d;
			tick_q     <= tick_end ? 8'h00 : tick_q + 8'h01;
			if (tick_end) begin
				sub_q <= sub_q + 4'h1;
				if (key_slot && sub_q <= `LEDKS_KEY_SRC_LAST) begin
					stage_q[{sub_q, 1'b0} +: 2] <= key_in;
				end
			end
			if (slot_end) begin
				if (key_slot || slot_q > last_grid) begin
					slot_q <= 3'h0;
					key_q  <= stage_q;
				end else begin
					slot_q <= slot_q + 3'h1;
				end
			end
		end
	end

endmodule

// ==== src/ledks_ctrl.v ====
// Top of the LED display and key scan controller: serial link, commands, RAM.
`timescale 1ns/1ps
`include "ledks_consts.vh"
module ledks_ctrl (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        frame_select,
	input  wire        shift_clk,
	input  wire        serial_data_line_in,
	output reg         serial_data_line_out,
	output reg         serial_data_line_oe_n,
	input  wire [1:0]  key_return_inputs,
	output wire [9:0]  segment_scan_outputs,
	output wire [2:0]  segment_or_grid_outputs,
	output wire [3:0]  grid_outputs,
	output reg  [1:0]  display_mode,
	output reg         display_on,
	output reg  [2:0]  pulse_width,
	output reg         test_mode,
	output reg         fifo_overrun
);

	// -----------------------------------------------------------------
	// Reset release and pin synchronisers
	// -----------------------------------------------------------------
	reg        rst_s1;
	reg        rst_s2;
	wire       rstn_i = rst_s2;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	reg        stb_s1;
	reg        stb_s2;
	reg        sck_s1;
	reg        sck_s2;
	reg        sck_s3;
	reg        din_s1;
	reg        din_s2;
	reg  [1:0] key_s1;
	reg  [1:0] key_s2;

	always @(posedge mclk or negedge rstn_i) begin
		if (!rstn_i) begin
			stb_s1 <= 1'b1;
			stb_s2 <= 1'b1;
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_s3 <= 1'b1;
			din_s1 <= 1'b1;
			din_s2 <= 1'b1;
			key_s1 <= 2'b00;
			key_s2 <= 2'b00;
		end else begin
			stb_s1 <= frame_select;
			stb_s2 <= stb_s1;
			sck_s1 <= shift_clk;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			din_s1 <= serial_data_line_in;
			din_s2 <= din_s1;
			key_s1 <= key_return_inputs;
			key_s2 <= key_s1;
		end
	end

	// Shift clock edges only count while the frame is open
	wire sck_rise = ~stb_s2 & sck_s2 & ~sck_s3;
	wire sck_fall = ~stb_s2 & ~sck_s2 & sck_s3;

	// -----------------------------------------------------------------
	// Serial receiver
	// -----------------------------------------------------------------
	reg  [7:0] rx_sr_q;
	reg  [2:0] rx_cnt_q;
	reg        rx_first_q;
	reg        rx_valid_q;
	reg  [7:0] rx_byte_q;
	reg        rx_cmd_q;
	reg        read_frame_q;
	wire       fifo_in_ready;
	wire [7:0] rx_sr_d = {din_s2, rx_sr_q[7:1]};

	always @(posedge mclk or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_sr_q      <= 8'h00;
			rx_cnt_q     <= 3'h0;
			rx_first_q   <= 1'b1;
			rx_valid_q   <= 1'b0;
			rx_byte_q    <= 8'h00;
			rx_cmd_q     <= 1'b0;
			fifo_overrun <= 1'b0;
		end else begin
			if (rx_valid_q && fifo_in_ready) begin
				rx_valid_q <= 1'b0;
			end
			if (stb_s2) begin
				rx_cnt_q   <= 3'h0;
				rx_first_q <= 1'b1;
			end else if (sck_rise) begin
				rx_sr_q  <= rx_sr_d;
				rx_cnt_q <= rx_cnt_q + 3'h1;
				// Host bits during a key read are don't-care and never queued
				if (rx_cnt_q == 3'h7 && !read_frame_q) begin
					rx_valid_q <= 1'b1;
					rx_byte_q  <= rx_sr_d;
					rx_cmd_q   <= rx_first_q;
					rx_first_q <= 1'b0;
					// A byte still waiting for room is overwritten; flagged sticky
					if (rx_valid_q && !fifo_in_ready) begin
						fifo_overrun <= 1'b1;
					end
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Byte queue toward the interpreter
	// -----------------------------------------------------------------
	wire       q_valid;
	wire       q_ready;
	wire [8:0] q_data;

	ledks_fifo #(
		.WIDTH (`LEDKS_FIFO_WIDTH),
		.DEPTH (`LEDKS_FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clk       (mclk),
		.rst_n     (rstn_i),
		.in_valid  (rx_valid_q),
		.in_ready  (fifo_in_ready),
		.in_data   ({rx_cmd_q, rx_byte_q}),
		.out_valid (q_valid),
		.out_ready (q_ready),
		.out_data  (q_data)
	);

	// -----------------------------------------------------------------
	// Command interpreter: one byte held, executed the next cycle
	// -----------------------------------------------------------------
	reg        hold_q;
	reg  [7:0] hold_byte_q;
	reg        hold_cmd_q;
	reg  [1:0] data_sel_q;
	reg        fixed_addr_q;
	reg  [3:0] addr_q;
	reg        ram_we;
	reg  [7:0] ram_q [0:`LEDKS_RAM_DEPTH-1];
	wire       addr_ok = (addr_q < `LEDKS_ADDR_LIMIT);

	// The hold stage halves the drain rate; the queue absorbs bursts
	assign q_ready = ~hold_q;

	always @(posedge mclk or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_q       <= 1'b0;
			hold_byte_q  <= 8'h00;
			hold_cmd_q   <= 1'b0;
			display_mode <= `LEDKS_MODE_RESET;
			display_on   <= 1'b0;
			pulse_width  <= `LEDKS_PW_RESET;
			data_sel_q   <= `LEDKS_DATA_WRITE;
			fixed_addr_q <= 1'b0;
			test_mode    <= 1'b0;
			addr_q       <= `LEDKS_ADDR_RESET;
			read_frame_q <= 1'b0;
			ram_we       <= 1'b0;
		end else begin
			ram_we <= 1'b0;
			if (q_valid && !hold_q) begin
				hold_q      <= 1'b1;
				hold_byte_q <= q_data[7:0];
				hold_cmd_q  <= q_data[8];
			end
			if (stb_s2) begin
				read_frame_q <= 1'b0;
			end
			if (hold_q) begin
				hold_q <= 1'b0;
				if (hold_cmd_q) begin
					case (hold_byte_q[7:6])
						`LEDKS_CMD_MODE: begin
							if (hold_byte_q[1:0] != display_mode) begin
								display_mode <= hold_byte_q[1:0];
								display_on   <= 1'b0;
							end
						end
						`LEDKS_CMD_DATA: begin
							data_sel_q   <= hold_byte_q[1:0];
							fixed_addr_q <= hold_byte_q[`LEDKS_B_FIXED];
							test_mode    <= hold_byte_q[`LEDKS_B_TEST];
							if (hold_byte_q[1:0] == `LEDKS_DATA_READ && !stb_s2) begin
								read_frame_q <= 1'b1;
							end
						end
						`LEDKS_CMD_CTRL: begin
							display_on  <= hold_byte_q[`LEDKS_B_ON];
							pulse_width <= hold_byte_q[2:0];
						end
						default: begin
							addr_q <= hold_byte_q[3:0];
						end
					endcase
				end else if (data_sel_q == `LEDKS_DATA_WRITE && addr_ok) begin
					ram_we <= 1'b1;
					if (!fixed_addr_q) begin
						addr_q <= addr_q + 4'h1;
					end
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Display RAM: write address captured before the pointer advances
	// -----------------------------------------------------------------
	reg  [3:0]   wr_addr_q;
	reg  [7:0]   wr_data_q;
	wire [111:0] ram_flat;

	always @(posedge mclk or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_addr_q <= `LEDKS_ADDR_RESET;
			wr_data_q <= 8'h00;
		end else if (hold_q) begin
			wr_addr_q <= addr_q;
			wr_data_q <= hold_byte_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < `LEDKS_RAM_DEPTH; i = i + 1) begin : g_ram
			always @(posedge mclk or negedge rstn_i) begin
				if (!rstn_i) begin
					ram_q[i] <= 8'h00;
				end else if (ram_we && wr_addr_q == i[3:0]) begin
					ram_q[i] <= wr_data_q;
				end
			end
			assign ram_flat[i*8 +: 8] = ram_q[i];
		end
	endgenerate

	// -----------------------------------------------------------------
	// Multiplexing and key scan
	// -----------------------------------------------------------------
	wire [19:0] key_data;

	ledks_scan u_scan (
		.clk        (mclk),
		.rst_n      (rstn_i),
		.mode       (display_mode),
		.disp_on    (display_on),
		.pulse_sel  (pulse_width),
		.ram_flat   (ram_flat),
		.key_in     (key_s2),
		.seg_q      (segment_scan_outputs),
		.seg_grid_q (segment_or_grid_outputs),
		.grid_q     (grid_outputs),
		.key_q      (key_data)
	);

	// -----------------------------------------------------------------
	// Key read transmitter
	// -----------------------------------------------------------------
	reg  [5:0] tx_idx_q;
	reg        tx_bit;
	wire [2:0] tx_byte = tx_idx_q[5:3];

	// Byte k: b0-b1 odd source, b3-b4 even source, other bits zero
	always @* begin
		case (tx_idx_q[2:0])
			3'h0:    tx_bit = key_data[{tx_byte, 2'b00}];
			3'h1:    tx_bit = key_data[{tx_byte, 2'b01}];
			3'h3:    tx_bit = key_data[{tx_byte, 2'b10}];
			3'h4:    tx_bit = key_data[{tx_byte, 2'b11}];
			default: tx_bit = 1'b0;
		endcase
	end

	always @(posedge mclk or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_idx_q              <= 6'h00;
			serial_data_line_out  <= 1'b0;
			serial_data_line_oe_n <= 1'b1;
		end else begin
			serial_data_line_out <= 1'b0;
			if (!read_frame_q) begin
				tx_idx_q              <= 6'h00;
				serial_data_line_oe_n <= 1'b1;
			end else if (sck_fall) begin
				serial_data_line_oe_n <= tx_bit;
				tx_idx_q <= (tx_idx_q == `LEDKS_KEY_BITS - 6'h01) ? 6'h00 : tx_idx_q + 6'h01;
			end
		end
	end

endmodule

// ==== testbench/ledks_ctrl_asserts.sv ====
// Port assertions for the LED display and key scan controller.
`timescale 1ns/1ps
module ledks_ctrl_chk (
	input wire       mclk,
	input wire       rst_n,
	input wire       frame_select,
	input wire       serial_data_line_out,
	input wire       serial_data_line_oe_n,
	input wire [2:0] segment_or_grid_outputs,
	input wire [3:0] grid_outputs,
	input wire [1:0] display_mode,
	input wire       display_on,
	input wire [2:0] pulse_width,
	input wire       test_mode,
	input wire       fifo_overrun
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	reg [5:0] hi_cnt_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			hi_cnt_q <= 6'h00;
		else if (!frame_select)
			hi_cnt_q <= 6'h00;
		else if (hi_cnt_q != 6'h3F)
			hi_cnt_q <= hi_cnt_q + 6'h01;
	end
	sequence s_strobe_idle;
		frame_select [*8];
	endsequence
	sequence s_dark;
		(display_on == 1'b0) [*3];
	endsequence
	a_never_high: assert property (serial_data_line_out == 1'b0)
		else $error("data line driven high");
	a_idle_release: assert property (s_strobe_idle |-> serial_data_line_oe_n)
		else $error("data line held low outside frame");
	a_reset_values: assert property ($rose(rst_n) |-> display_mode == 2'b11 && !display_on
		&& pulse_width == 3'h0 && !test_mode && !fifo_overrun)
		else $error("wrong values after reset");
	a_mode_blanks: assert property ($changed(display_mode) |-> ##[0:1] !display_on)
		else $error("display left on after mode change");
	a_dark_off: assert property (s_dark |-> grid_outputs == 4'h0 && segment_or_grid_outputs == 3'h0)
		else $error("grids driven while display off");
	a_single_grid: assert property ($onehot0(grid_outputs))
		else $error("two grids active");
	// Settings must hold still once the strobe has stayed high for 40 cycles
	a_quiet_strobe: assert property (hi_cnt_q >= 6'h28 |-> $stable(display_mode) && $stable(display_on)
		&& $stable(pulse_width) && $stable(test_mode))
		else $error("setting changed with strobe high");
	a_overrun_sticky: assert property (fifo_overrun |=> fifo_overrun)
		else $error("overrun flag dropped");
endmodule
bind ledks_ctrl ledks_ctrl_chk ledks_ctrl_chk_inst (.mclk, .rst_n, .frame_select, .serial_data_line_out,
	.serial_data_line_oe_n, .segment_or_grid_outputs, .grid_outputs, .display_mode, .display_on,
	.pulse_width, .test_mode, .fifo_overrun);

// ==== testbench/ledks_host_model.sv ====
// Host side of the three-wire link: strobe, shift clock and data line.
`timescale 1ns/1ps
module ledks_host_model (
	input  wire mclk,
	input  wire line,
	output reg  frame_select,
	output reg  shift_clk,
	output reg  host_data,
	output reg  host_drive
);
	// ----------------------------------------
	// Link tasks, called just after an mclk edge
	// ----------------------------------------
	integer gap = 0;
	initial begin
		frame_select = 1'b1;
		shift_clk    = 1'b1;
		host_data    = 1'b1;
		host_drive   = 1'b0;
	end
	task ticks(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	task open_frame;
		begin
			frame_select <= 1'b0;
			ticks(4);
		end
	endtask
	task close_frame;
		begin
			ticks(4);
			frame_select <= 1'b1;
			host_drive   <= 1'b0;
			ticks(40);
		end
	endtask
	// Shift clock idles high after each bit, whether or not a frame is open
	task send_bits(input [7:0] b, input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				shift_clk  <= 1'b0;
				host_drive <= 1'b1;
				host_data  <= b[i];
				ticks(4 + gap);
				shift_clk <= 1'b1;
				ticks(4);
			end
		end
	endtask
	task read_cmd;
		begin
			send_bits(8'h42, 8);
			host_drive <= 1'b0;
			ticks(40);
		end
	endtask
	task recv_byte(output [7:0] b);
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				shift_clk <= 1'b0;
				ticks(4);
				#1 b[i] = line;
				@(posedge mclk);
				shift_clk <= 1'b1;
				ticks(3);
			end
		end
	endtask
endmodule

// ==== testbench/led_display_key_scan_ctrl_test.sv ====
// Self-checking bench for the LED display and key scan controller.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin check_count = check_count + 1; if ((got) !== (exp)) begin mismatches = mismatches + 1; $display("[FAIL] %0t %s", $time, msg); end end
module led_display_key_scan_ctrl_test;
	// ----------------------------------------
	// Harness
	// ----------------------------------------
	reg         mclk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [1:0]  key_return_inputs = 2'h0;
	reg  [19:0] keys = 20'h00000;
	reg  [7:0]  b;
	reg  [31:0] r;
	integer     mismatches = 0;
	integer     check_count = 0;
	integer     i, k, bad, lit, grc, sgc;
	wire        frame_select, shift_clk, host_data, host_drive, line;
	wire        serial_data_line_out, serial_data_line_oe_n, display_on, test_mode, fifo_overrun;
	wire [9:0]  segment_scan_outputs;
	wire [2:0]  segment_or_grid_outputs, pulse_width;
	wire [3:0]  grid_outputs;
	wire [1:0]  display_mode;
	// Pull-up when neither side pulls the line
	assign line = !serial_data_line_oe_n ? serial_data_line_out : (host_drive ? host_data : 1'b1);
	always #12.5 mclk = ~mclk;
	ledks_ctrl ledks_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .frame_select(frame_select), .shift_clk(shift_clk),
		.serial_data_line_in(line), .serial_data_line_out(serial_data_line_out),
		.serial_data_line_oe_n(serial_data_line_oe_n), .key_return_inputs(key_return_inputs),
		.segment_scan_outputs(segment_scan_outputs), .segment_or_grid_outputs(segment_or_grid_outputs),
		.grid_outputs(grid_outputs), .display_mode(display_mode), .display_on(display_on),
		.pulse_width(pulse_width), .test_mode(test_mode), .fifo_overrun(fifo_overrun));
	ledks_host_model ledks_host_model_inst (.mclk(mclk), .line(line), .frame_select(frame_select),
		.shift_clk(shift_clk), .host_data(host_data), .host_drive(host_drive));
	// Key matrix: a pressed key joins its source to its return
	function [1:0] matrix(input [9:0] src);
		integer s;
		begin
			matrix = 2'h0;
			for (s = 0; s < 10; s = s + 1)
				if (src[s])
					matrix = matrix | keys[2*s +: 2];
		end
	endfunction
	always @(posedge mclk) key_return_inputs <= matrix(segment_scan_outputs);
	function [7:0] key_byte(input integer n);
		key_byte = {3'h0, keys[4*n+3], keys[4*n+2], 1'b0, keys[4*n+1], keys[4*n]};
	endfunction
	task frame(input [7:0] c);
		begin
			ledks_host_model_inst.open_frame;
			ledks_host_model_inst.send_bits(c, 8);
			ledks_host_model_inst.close_frame;
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", check_count, mismatches);
			if (mismatches == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		#2500000;
		mismatches = mismatches + 1;
		$display("[FAIL] %0t run limit reached", $time);
		report_and_stop;
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		r = $urandom(51668);
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		`CHK(display_mode, 2'b11, "reset mode")
		`CHK({display_on, pulse_width, test_mode}, 5'h00, "reset control")
		$display("test reset done");
		for (i = 0; i < 4; i = i + 1) begin
			r = $urandom;
			frame(8'h8F);
			frame({2'b00, r[3:0], i[1:0]});
			`CHK(display_mode, i[1:0], "mode select")
			`CHK(display_on, 1'b0, "mode blank")
			frame(8'h8F);
			frame({2'b00, r[7:4], i[1:0]});
			`CHK(display_on, 1'b1, "same mode kept")
		end
		$display("test mode done");
		for (i = 0; i < 8; i = i + 1) begin
			frame({5'b10001, i[2:0]});
			`CHK({display_on, pulse_width}, {1'b1, i[2:0]}, "control on")
			frame({5'b10000, i[2:0]});
			`CHK(display_on, 1'b0, "control off")
		end
		r = $urandom;
		frame({2'b01, r[1:0], 4'h8});
		`CHK(test_mode, 1'b1, "test mode on")
		frame({2'b01, r[3:2], 4'h0});
		`CHK(test_mode, 1'b0, "test mode off")
		$display("test control done");
		ledks_host_model_inst.open_frame;
		ledks_host_model_inst.send_bits(8'h8F, 5);
		ledks_host_model_inst.close_frame;
		ledks_host_model_inst.send_bits(8'hFF, 8);
		ledks_host_model_inst.ticks(40);
		frame(8'h8A);
		`CHK({display_on, pulse_width}, 4'hA, "after partial byte")
		$display("test framing done");
		frame(8'h40);
		ledks_host_model_inst.open_frame;
		ledks_host_model_inst.send_bits(8'hC0, 8);
		ledks_host_model_inst.send_bits(8'h5A, 8);
		for (i = 0; i < 13; i = i + 1)
			ledks_host_model_inst.send_bits(8'h00, 8);
		ledks_host_model_inst.close_frame;
		// Bytes past an invalid address must not wrap round into address 00H
		ledks_host_model_inst.open_frame;
		ledks_host_model_inst.send_bits(8'hCE, 8);
		for (i = 0; i < 3; i = i + 1)
			ledks_host_model_inst.send_bits(8'hFF, 8);
		ledks_host_model_inst.close_frame;
		frame(8'h44);
		ledks_host_model_inst.open_frame;
		ledks_host_model_inst.send_bits(8'hC2, 8);
		ledks_host_model_inst.send_bits(8'h33, 8);
		ledks_host_model_inst.send_bits(8'h00, 8);
		ledks_host_model_inst.close_frame;
		frame(8'h40);
		frame(8'h8F);
		bad = 0;
		lit = 0;
		grc = 0;
		sgc = 0;
		// Exactly two display frames of eight slots, so the lit count is exact
		repeat (10240) begin
			@(posedge mclk);
			#1;
			if (grid_outputs == 4'h1 && segment_scan_outputs != 10'h000) begin
				lit = lit + 1;
				if (segment_scan_outputs != 10'h05A)
					bad = bad + 1;
			end else if (grid_outputs != 4'h0 && segment_scan_outputs != 10'h000)
				bad = bad + 1;
			if (grid_outputs != 4'h0)
				grc = grc + 1;
			// Seven grid mode: shared pins act as grids only, one at a time
			if (segment_or_grid_outputs != 3'h0) begin
				sgc = sgc + 1;
				if (grid_outputs != 4'h0 || segment_scan_outputs != 10'h000)
					bad = bad + 1;
			end
		end
		`CHK(bad, 0, "display segments")
		`CHK(lit, 1120, "pulse width and duty")
		`CHK(grc, 4 * 16 * 40 * 2, "plain grid time")
		`CHK(sgc, 3 * 16 * 40 * 2, "shared grid time")
		$display("test display done");
		for (k = 0; k < 3; k = k + 1) begin
			keys = (k == 0) ? 20'hFFFFF : 20'($urandom);
			ledks_host_model_inst.gap = k * 3;
			repeat (11000) @(posedge mclk);
			ledks_host_model_inst.open_frame;
			ledks_host_model_inst.read_cmd;
			for (i = 0; i < 6; i = i + 1) begin
				ledks_host_model_inst.recv_byte(b);
				`CHK(b, key_byte(i % 5), "key byte")
			end
			ledks_host_model_inst.close_frame;
		end
		`CHK(fifo_overrun, 1'b0, "no byte lost")
		$display("test keys done");
		report_and_stop;
	end
endmodule
